//--- core/tkp_pkg.sv
// Function
// - All reference, delta and threshold arithmetic uses 16-bit operands.
// - Each channel's reference slews toward the signal only while not detecting.
// - Threshold and hysteresis levels are taken relative to the current reference.
// - Reference follows a falling signal faster than a rising one.
// - Slow mode drift steps: 90 ms per sleep burst, 18 ms per sync pulse.
// - Detection threshold is twelve counts above reference on every channel.
// - Detected key releases once delta drops below threshold minus two.
// - Continuous detection longer than the selected maximum recalibrates the channel.
// - Maximum detection is ten seconds, sixty seconds, or infinite (no recalibration).
// - Stuck-key timing and recalibration are separate for every channel.
// - Fast mode timeouts count clock-derived units; so do slow mode ones, except bursts woken by sync.
// - Slow mode with sync counts each sync pulse as 18 ms.
// - Integrator counts detecting samples; one miss before the limit clears it.
// - Key goes active after six consecutive detecting samples.
// - Slow mode runs confirming bursts back to back, without sleeping.
// - All channels recalibrate at power-up before detection starts.
// - Reset pin held low at least 10 us then released recalibrates all.
// - Signal five counts below reference for two seconds recalibrates the channel.
// - Straps are read at power-up and every ten seconds without any touch.
// - A strap read takes 25 samples over 250 us; all must agree.
// - Straps a/b: 01 10 s, 10 60 s, 11 toggle 10 s, 00 infinite.
// - Toggle output flips only on detection onset; timeouts leave it alone.
// - Slow mode: sync wakes one burst; else wake after about 90 ms.
package tkp_pkg;
  localparam int CH_NUM = 4;
  localparam int DW     = 16;
  localparam int MSW    = 17;
  localparam int CRW    = 7;
  localparam int TMRW   = 24;
  localparam int RSTW   = 10;

  localparam logic [DW-1:0] THRESH    = 16'h000c;
  localparam logic [DW-1:0] HYST      = 16'h0002;
  localparam logic [DW-1:0] NEG_LIM   = 16'h0005;
  localparam logic [DW-1:0] REF_STEP  = 16'h0001;
  localparam logic [2:0]    INTEG_LIM = 3'h6;

  localparam int CLK_NS      = 10;
  localparam int MS_NS       = 1000000;
  localparam int MS_CYC      = MS_NS / CLK_NS;
  localparam int SLEEP_MS    = 90;
  localparam int SLEEP_CYC   = SLEEP_MS * MS_CYC;
  localparam int SYNC_MS     = 18;
  localparam int FAST_MS     = 1;
  localparam int STUCK10_MS  = 10000;
  localparam int STUCK60_MS  = 60000;
  localparam int NEG_MS      = 2000;
  localparam int OPT_MS      = 10000;
  localparam int DRIFT_DN_MS = 100;
  localparam int DRIFT_UP_MS = 1000;
  localparam int OPT_N       = 25;
  localparam int OPT_WIN_NS  = 250000;
  localparam int OPT_SP_CYC  = OPT_WIN_NS / (OPT_N * CLK_NS);
  localparam int RST_MIN_NS  = 10000;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {TMO_10S, TMO_60S, TMO_INF} tkp_tmo_e;
  typedef enum logic {ST_BOOT, ST_RUN} tkp_st_e;

  typedef struct packed {
    logic rst_n;
    logic sync;
    logic speed;
    logic rca;
    logic rcb;
  } tkp_pins_s;

  typedef struct packed {
    tkp_pins_s s1;
    tkp_pins_s s2;
  } tkp_sync_s;

  typedef struct packed {
    logic slow;
    logic rca;
    logic rcb;
  } tkp_opt_s;

  typedef struct packed {
    logic            busy;
    logic [4:0]      cnt;
    logic [9:0]      tick;
    tkp_opt_s        first;
    logic            agree;
    logic            done;
    logic            ok;
  } tkp_smp_s;

  typedef struct packed {
    logic [DW-1:0]  refv;
    logic [2:0]     integ;
    logic           det;
    logic           tog;
    logic           pend;
    logic [MSW-1:0] stuck;
    logic [MSW-1:0] neg;
    logic [MSW-1:0] dn;
    logic [MSW-1:0] up;
  } tkp_ch_s;

  typedef struct packed {
    tkp_st_e                st;
    logic                   rst_prev;
    logic                   sync_prev;
    logic [RSTW-1:0]        lowc;
    tkp_opt_s               opt;
    logic [MSW-1:0]         optc;
    logic [TMRW-1:0]        tmr;
    logic                   want;
    logic [CRW-1:0]         want_cr;
    logic                   busy;
    logic [CRW-1:0]         cr;
    logic                   recal;
    logic                   burst;
    logic                   sleep;
    logic                   smp_start;
    logic [CH_NUM-1:0]      key;
    tkp_ch_s [CH_NUM-1:0]   ch;
  } tkp_top_s;

  function automatic tkp_tmo_e tkp_tmo(input tkp_opt_s o);
    case ({o.rca, o.rcb})
      2'b01, 2'b11: tkp_tmo = TMO_10S;
      2'b10:        tkp_tmo = TMO_60S;
      default:      tkp_tmo = TMO_INF;
    endcase
  endfunction

  function automatic logic [MSW-1:0] tkp_lim(input tkp_tmo_e t);
    case (t)
      TMO_60S: tkp_lim = MSW'(STUCK60_MS);
      default: tkp_lim = MSW'(STUCK10_MS);
    endcase
  endfunction
endpackage

//--- core/tkp_sync2.sv
`timescale 1ns/1ps
module tkp_sync2
  import tkp_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  tkp_pins_s      pins_i,
  output tkp_pins_s      pins_o
);
  tkp_sync_s s;
  tkp_sync_s n;

  assign pins_o = s.s2;

  always_comb begin
    n    = s;
    n.s1 = pins_i;
    n.s2 = s.s1;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

//--- core/tkp_opt_sampler.sv
`timescale 1ns/1ps
module tkp_opt_sampler
  import tkp_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  wire logic      start_i,
  input  tkp_opt_s       strap_i,
  output logic           busy_o,
  output logic           done_o,
  output logic           ok_o,
  output tkp_opt_s       val_o
);
  localparam logic [9:0] SP_LIM = 10'(OPT_SP_CYC - 1);
  localparam logic [4:0] N_LIM  = 5'(OPT_N - 1);

  tkp_smp_s s;
  tkp_smp_s n;
  logic     same;

  assign same   = (strap_i == s.first);
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign ok_o   = s.ok;
  assign val_o  = s.first;

  always_comb begin
    n      = s;
    n.done = 1'b0;
    if (start_i && !s.busy) begin
      n.busy = 1'b1;
      n.cnt  = '0;
      n.tick = '0;
    end else if (s.busy) begin
      if (s.tick == SP_LIM) begin
        n.tick = '0;
        n.cnt  = s.cnt + 5'h01;
        if (s.cnt == 5'h00) begin
          n.first = strap_i;
          n.agree = 1'b1;
        end else begin
          n.agree = s.agree && same;
        end
        if (s.cnt == N_LIM) begin
          n.busy = 1'b0;
          n.done = 1'b1;
          n.ok   = s.agree && same;
        end
      end else begin
        n.tick = s.tick + 10'h001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  AST_DISAGREE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s.busy && s.tick == SP_LIM && s.cnt != 5'h00 && !same) |=> !s.agree)
    else $error("strap disagreement not recorded");
endmodule

//--- core/tkp_top.sv
`timescale 1ns/1ps
module tkp_top
  import tkp_pkg::*;
#(
  parameter int MS_CYCLES    = MS_CYC,
  parameter int SLEEP_CYCLES = SLEEP_CYC
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     recal_reset_n_i,
  input  wire logic                     sync_i,
  input  wire logic                     speed_strap_i,
  input  wire logic                     recal_strap_a_i,
  input  wire logic                     recal_strap_b_i,
  input  wire logic                     sample_valid_i,
  input  wire logic [CH_NUM-1:0][DW-1:0] raw_i,
  output logic                          burst_req_o,
  output logic                          sleep_o,
  output logic [CH_NUM-1:0]             key_o
);
  localparam logic [TMRW-1:0] FAST_LIM = TMRW'(MS_CYCLES - 1);
  localparam logic [TMRW-1:0] SLOW_LIM = TMRW'(SLEEP_CYCLES - 1);
  localparam logic [RSTW-1:0] RST_LIM  = RSTW'(RST_MIN_CYC);

  tkp_top_s          s;
  tkp_top_s          n;
  tkp_pins_s         pin_raw;
  tkp_pins_s         pin;
  tkp_opt_s          strap;
  tkp_opt_s          smp_val;
  logic              smp_busy;
  logic              smp_done;
  logic              smp_ok;
  logic [CH_NUM-1:0] chbusy;
  logic [CH_NUM-1:0] chdet;
  logic              confirm;
  logic              take;

  assign pin_raw = '{rst_n: recal_reset_n_i, sync: sync_i, speed: speed_strap_i,
                     rca: recal_strap_a_i, rcb: recal_strap_b_i};
  assign strap   = '{slow: pin.speed, rca: pin.rca, rcb: pin.rcb};

  tkp_sync2 u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pins_i  (pin_raw),
    .pins_o  (pin)
  );

  tkp_opt_sampler u_smp (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .start_i (s.smp_start),
    .strap_i (strap),
    .busy_o  (smp_busy),
    .done_o  (smp_done),
    .ok_o    (smp_ok),
    .val_o   (smp_val)
  );

  genvar g;
  for (g = 0; g < CH_NUM; g++) begin : g_flag
    assign chbusy[g] = (s.ch[g].integ != 3'h0);
    assign chdet[g]  = s.ch[g].det;
  end

  // Pending confirmation keeps a slow-mode device awake
  assign confirm = (s.st == ST_RUN) && s.opt.slow && (|chbusy);
  assign take    = sample_valid_i && s.busy;

  assign burst_req_o = s.burst;
  assign sleep_o     = s.sleep;
  assign key_o       = s.key;

  always_comb begin
    tkp_ch_s               c;
    logic signed [DW-1:0]  d;
    logic                  rc;
    tkp_tmo_e              tmo;
    logic [MSW-1:0]        oc;
    c   = '0;
    d   = '0;
    rc  = 1'b0;
    tmo = tkp_tmo(s.opt);
    oc  = s.optc + MSW'(s.cr);
    n   = s;
    n.burst     = 1'b0;
    n.recal     = 1'b0;
    n.smp_start = 1'b0;
    n.rst_prev  = pin.rst_n;
    n.sync_prev = pin.sync;

    // Reset pin low time, saturating at the minimum
    if (!pin.rst_n) begin
      if (s.lowc != RST_LIM) begin
        n.lowc = s.lowc + RSTW'(1);
      end
    end else begin
      n.lowc = '0;
    end
    if (pin.rst_n && !s.rst_prev && s.lowc == RST_LIM) begin
      n.recal = 1'b1;
    end

    // Option reads; a failed read leaves the old settings in place
    if (smp_done) begin
      if (smp_ok) begin
        n.opt = smp_val;
      end
      if (s.st == ST_BOOT) begin
        if (smp_ok) begin
          n.st    = ST_RUN;
          n.recal = 1'b1;
        end else begin
          n.smp_start = 1'b1;
        end
      end
    end
    if (s.st == ST_RUN && take && chdet == '0 && !smp_busy) begin
      if (oc >= MSW'(OPT_MS)) begin
        n.optc      = '0;
        n.smp_start = 1'b1;
      end else begin
        n.optc = oc;
      end
    end

    // Burst scheduling
    if (take) begin
      n.busy = 1'b0;
    end
    if (s.st == ST_RUN) begin
      if (!s.busy && (s.want || confirm)) begin
        n.burst = 1'b1;
        n.busy  = 1'b1;
        n.cr    = s.want ? s.want_cr : '0;
        n.want  = 1'b0;
      end
      if (s.opt.slow && pin.sync && !s.sync_prev) begin
        n.tmr     = '0;
        n.want    = 1'b1;
        n.want_cr = CRW'(SYNC_MS);
      end else if (s.tmr >= (s.opt.slow ? SLOW_LIM : FAST_LIM)) begin
        n.tmr     = '0;
        n.want    = 1'b1;
        n.want_cr = s.opt.slow ? CRW'(SLEEP_MS) : CRW'(FAST_MS);
      end else begin
        n.tmr = s.tmr + TMRW'(1);
      end
    end
    n.sleep = (n.st == ST_RUN) && s.opt.slow && !n.busy && !confirm;

    // Per-channel processing, 16-bit reference and delta arithmetic, 17-bit timers
    for (int i = 0; i < CH_NUM; i++) begin
      c  = s.ch[i];
      d  = $signed(raw_i[i] - c.refv);
      rc = c.pend;
      if (take && !c.pend) begin
        if (d <= -$signed(NEG_LIM)) begin
          c.neg = c.neg + MSW'(s.cr);
          rc    = (c.neg >= MSW'(NEG_MS));
        end else begin
          c.neg = '0;
        end
        if (c.det) begin
          if (d < $signed(THRESH - HYST)) begin
            c.det   = 1'b0;
            c.stuck = '0;
          end else if (tmo != TMO_INF) begin
            c.stuck = c.stuck + MSW'(s.cr);
            if (c.stuck > tkp_lim(tmo)) begin
              rc = 1'b1;
            end
          end
        end else if (d >= $signed(THRESH)) begin
          c.integ = c.integ + 3'h1;
          if (c.integ == INTEG_LIM) begin
            c.det   = 1'b1;
            c.integ = 3'h0;
            c.tog   = ~c.tog;
          end
        end else begin
          c.integ = 3'h0;
          if (d[DW-1]) begin
            c.up = '0;
            c.dn = c.dn + MSW'(s.cr);
            if (c.dn >= MSW'(DRIFT_DN_MS)) begin
              c.dn   = '0;
              c.refv = c.refv - REF_STEP;
            end
          end else if (d != '0) begin
            c.dn = '0;
            c.up = c.up + MSW'(s.cr);
            if (c.up >= MSW'(DRIFT_UP_MS)) begin
              c.up   = '0;
              c.refv = c.refv + REF_STEP;
            end
          end
        end
      end
      if (take && rc) begin
        c.refv  = raw_i[i];
        c.integ = 3'h0;
        c.det   = 1'b0;
        c.stuck = '0;
        c.neg   = '0;
        c.dn    = '0;
        c.up    = '0;
        c.pend  = 1'b0;
      end
      // A new request wins over the one being served
      if (s.recal) begin
        c.pend = 1'b1;
      end
      n.ch[i]  = c;
      n.key[i] = (s.opt.rca && s.opt.rcb) ? c.tog : c.det;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s           <= '0;
      s.smp_start <= 1'b1;
    end else begin
      s <= n;
    end
  end

  sequence s_take;
    sample_valid_i && s.busy;
  endsequence

  sequence s_pin_release;
    pin.rst_n && !s.rst_prev && s.lowc == RST_LIM;
  endsequence

  AST_PIN_RECAL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_pin_release |=> s.recal ##1 (&{s.ch[0].pend, s.ch[CH_NUM-1].pend}))
    else $error("pin reset did not request recalibration");

  AST_CONFIRM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (confirm && !s.busy && !s.want) |=> s.burst && s.cr == '0)
    else $error("confirming burst not issued back to back");

  AST_KEEP_OPT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (smp_done && !smp_ok) |=> $stable(s.opt))
    else $error("options changed on a disagreeing read");

  for (g = 0; g < CH_NUM; g++) begin : g_ast
    logic signed [DW-1:0] ad;
    assign ad = $signed(raw_i[g] - s.ch[g].refv);

    AST_RELEASE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_take ##0 (s.ch[g].det && !s.ch[g].pend && ad < $signed(THRESH - HYST))
      |=> !s.ch[g].det)
      else $error("key not released below hysteresis level");

    AST_MISS_CLEARS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_take ##0 (!s.ch[g].det && !s.ch[g].pend && ad < $signed(THRESH))
      |=> s.ch[g].integ == 3'h0 && !s.ch[g].det)
      else $error("integrator not cleared by a miss");

    AST_ARM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $rose(s.ch[g].det) |-> $past(s.ch[g].integ) == INTEG_LIM - 3'h1)
      else $error("detection without six confirmations");

    AST_NO_DRIFT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_take ##0 (s.ch[g].det && !s.ch[g].pend) |=> $stable(s.ch[g].refv) || !s.ch[g].det)
      else $error("reference moved during detection");

    AST_RECAL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      s_take ##0 s.ch[g].pend |=> s.ch[g].refv == $past(raw_i[g]) && !s.ch[g].det
      && s.ch[g].integ == 3'h0)
      else $error("recalibration did not reload the reference");
  end
endmodule

//--- test/tkp_afe_model.sv
`timescale 1ns/1ps
module tkp_afe_model
  import tkp_pkg::*;
(
  input  wire logic                      mclk_i,
  input  wire logic                      burst_req_i,
  input  wire logic [3:0]                lat_i,
  input  wire logic [CH_NUM-1:0][DW-1:0] level_i,
  output logic                           sample_valid_o,
  output logic [CH_NUM-1:0][DW-1:0]      raw_o
);
  logic [CH_NUM-1:0][DW-1:0] last;

  // Answers each burst request after a variable latency with one valid cycle;
  // outside it the data lines show the inverse of the last result
  initial begin
    sample_valid_o = 1'b0;
    raw_o = '0;
    last = '0;
    forever begin
      @(posedge mclk_i iff burst_req_i);
      repeat (lat_i) @(posedge mclk_i);
      #1;
      sample_valid_o = 1'b1;
      raw_o = level_i;
      last = level_i;
      @(posedge mclk_i);
      #1;
      sample_valid_o = 1'b0;
      raw_o = ~last;
    end
  end
endmodule

//--- test/tkp_top_tb_top.sv
`timescale 1ns/1ps
module tkp_top_tb_top
  import tkp_pkg::*;
;
  localparam int LIMIT_CYC = 90000;

  logic                      mclk_i;
  logic                      rst_n_i;
  logic                      recal_reset_n_i;
  logic                      sync_i;
  logic                      speed_strap_i;
  logic                      recal_strap_a_i;
  logic                      recal_strap_b_i;
  logic                      sample_valid;
  logic [CH_NUM-1:0][DW-1:0] raw;
  logic [CH_NUM-1:0][DW-1:0] level;
  logic                      burst_req;
  logic                      sleep;
  logic [CH_NUM-1:0]         key_o;
  logic [3:0]                lat;
  logic [DW-1:0]             base [CH_NUM];
  logic [CH_NUM-1:0]         det;
  logic [CH_NUM-1:0]         tog;
  logic                      tog_mode;
  int                        integ [CH_NUM];
  int                        miscompares;
  int                        samples_checked;
  int                        cyc;
  int                        c;

  tkp_top #(.MS_CYCLES(40), .SLEEP_CYCLES(200)) u_tkp_top (
    .mclk_i          (mclk_i),
    .rst_n_i         (rst_n_i),
    .recal_reset_n_i (recal_reset_n_i),
    .sync_i          (sync_i),
    .speed_strap_i   (speed_strap_i),
    .recal_strap_a_i (recal_strap_a_i),
    .recal_strap_b_i (recal_strap_b_i),
    .sample_valid_i  (sample_valid),
    .raw_i           (raw),
    .burst_req_o     (burst_req),
    .sleep_o         (sleep),
    .key_o           (key_o)
  );

  tkp_afe_model u_tkp_afe_model (
    .mclk_i         (mclk_i),
    .burst_req_i    (burst_req),
    .lat_i          (lat),
    .level_i        (level),
    .sample_valid_o (sample_valid),
    .raw_o          (raw)
  );

  initial mclk_i = 1'b0;
  always #5 mclk_i = ~mclk_i;

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT_CYC) begin
      miscompares = miscompares + 1;
      $display("ERROR %0t run timed out", $time);
      test_done();
    end
  end

  task automatic chk_key(input logic [CH_NUM-1:0] exp, input string what);
    samples_checked = samples_checked + 1;
    if (key_o !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %0t %s key %b expected %b", $time, what, key_o, exp);
    end
  endtask

  task automatic chk_sleep(input logic exp, input string what);
    samples_checked = samples_checked + 1;
    if (sleep !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %0t %s sleep %b expected %b", $time, what, sleep, exp);
    end
  endtask

  // Expected per-sample key processing of one channel
  function automatic void step(input int ch, input int d);
    if (det[ch]) begin
      if (d < 10) det[ch] = 1'b0;
    end else if (d >= 12) begin
      integ[ch] = integ[ch] + 1;
      if (integ[ch] == 6) begin
        det[ch] = 1'b1;
        tog[ch] = ~tog[ch];
        integ[ch] = 0;
      end
    end else begin
      integ[ch] = 0;
    end
  endfunction

  // Waits for n accepted samples, then lets the key update settle
  task automatic smp(input int n);
    repeat (n) @(posedge mclk_i iff sample_valid);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic drive(input int ch, input int d, input int n);
    level[ch] = base[ch] + DW'(d);
    repeat (n) begin
      lat = 4'($urandom_range(0, 9));
      smp(1);
      step(ch, d);
      chk_key(tog_mode ? tog : det, "sample");
    end
  endtask

  task automatic boot(input logic a, input logic b);
    rst_n_i = 1'b0;
    recal_strap_a_i = a;
    recal_strap_b_i = b;
    tog_mode = a & b;
    det = '0;
    tog = '0;
    for (int i = 0; i < CH_NUM; i++) begin
      integ[i] = 0;
      base[i] = DW'($urandom_range(256, 28672));
      level[i] = base[i];
    end
    repeat (4) @(negedge mclk_i);
    chk_key('0, "in reset");
    rst_n_i = 1'b1;
    smp(2);
    chk_key('0, "after boot");
    chk_sleep(speed_strap_i, "after boot");
  endtask

  task automatic pin_low(input int n);
    recal_reset_n_i = 1'b0;
    repeat (n) @(negedge mclk_i);
    recal_reset_n_i = 1'b1;
  endtask

  initial begin
    rst_n_i = 1'b0;
    recal_reset_n_i = 1'b1;
    sync_i = 1'b0;
    speed_strap_i = 1'b0;
    recal_strap_a_i = 1'b0;
    recal_strap_b_i = 1'b0;
    lat = 4'h0;
    level = '0;
    miscompares = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(44183));
    boot(1'b0, 1'b0);
    c = $urandom_range(0, CH_NUM - 1);
    drive(c, 11, 7);
    drive(c, 12, 6);
    drive(c, 10, 2);
    drive(c, 9, 1);
    drive(c, 30, 5);
    drive(c, 0, 1);
    drive(c, 30, 6);
    drive(c, 0, 1);
    $display("threshold and integrator test done");
    repeat (4) begin
      c = $urandom_range(0, CH_NUM - 1);
      drive(c, $urandom_range(12, 200), 6);
      drive(c, $urandom_range(0, 9), 1);
    end
    $display("random touch test done");
    drive(c, 20, 6);
    pin_low(500);
    drive(c, 20, 2);
    pin_low(1100);
    repeat (5) @(negedge mclk_i);
    base[c] = level[c];
    det = '0;
    for (int i = 0; i < CH_NUM; i++) integ[i] = 0;
    drive(c, 0, 2);
    $display("recalibration pin test done");
    boot(1'b1, 1'b1);
    c = $urandom_range(0, CH_NUM - 1);
    drive(c, 25, 6);
    drive(c, 0, 2);
    drive(c, 25, 6);
    $display("toggle test done");
    test_done();
  end
endmodule
